// ### rtl/dma_chan_ctrl.sv
// DMA channel controller: event latch, parameter sets, issue, completion
// ********************************************************
// What this block does
// - Source and destination addresses are 32 bits for each transfer.
// - Each set holds three counts, source, destination and options.
// - First-dimension sync issues one array of first-count bytes per event.
// - Two-dimension sync issues a whole frame per event.
// - Separate source and destination strides, shared counts.
// - Addresses either increment or stay fixed for FIFO sides.
// - Finished set reloads from its linked set, bounded by set count.
// - Completion may raise a request on a chained channel.
// - Request events from peripherals start channel transfers.
// - A request event sets and holds its pending bit.
// - Writing one to event-set low or high triggers; zero does nothing.
// - Sixty-four channels, each usable for receive or transmit.
// - Sixty-four parameter sets sit in the register space.
// - One completion interrupt output per shadow region.
// - Final enable alone interrupts after the last request.
// - Intermediate enable alone interrupts after all but the last.
// - Both enables interrupt after every request.
// - Interrupts for final, intermediate completion and errors.
// - Watermark and threshold tracking plus error and status recording.
// ********************************************************
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module dma_chan_ctrl (
  input  wire logic                  i_clk,
  input  wire logic                  i_sys_rst,
  input  wire logic [11:0]           i_addr,
  input  wire logic [31:0]           i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic      [31:0]           o_rdata,
  input  wire logic [63:0]           i_dma_evt,
  output dma_chan_pkg::tr_s          o_tr,
  input  wire logic                  i_tr_ready,
  input  wire logic                  i_tr_done,
  output logic      [1:0]            o_irq,
  output logic                       o_err_irq
);
  // ********************************************************
  // Functions
  // ********************************************************
  function automatic logic [31:0] sext(input logic [15:0] v);
    sext = {{16{v[15]}}, v};
  endfunction

  function automatic logic [5:0] first_one(input logic [63:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 63; i >= 0; i--) begin
      if (v[i]) begin
        r = 6'(i);
      end
    end
    first_one = r;
  endfunction

  function automatic logic [6:0] count_ones(input logic [63:0] v);
    logic [6:0] r;
    r = 7'h00;
    for (int i = 0; i < 64; i++) begin
      r = r + {6'h00, v[i]};
    end
    count_ones = r;
  endfunction

  function automatic logic [31:0] word_of(input dma_chan_pkg::set_a_s p,
                                          input logic [2:0] w);
    case (w)
      3'h0: word_of = p.opt;
      3'h1: word_of = p.src;
      3'h2: word_of = {p.second_dim_count, p.first_dim_count};
      3'h3: word_of = p.dst;
      3'h4: word_of = {p.dbidx, p.sbidx};
      3'h5: word_of = {p.brld, p.link};
      3'h6: word_of = {p.dcidx, p.scidx};
      default: word_of = {16'h0000, p.third_dim_count};
    endcase
  endfunction

  function automatic dma_chan_pkg::set_a_s put_word(
      input dma_chan_pkg::set_a_s p, input logic [2:0] w,
      input logic [31:0] d);
    dma_chan_pkg::set_a_s r;
    r = p;
    case (w)
      3'h0: r.opt = d;
      3'h1: r.src = d;
      3'h2: {r.second_dim_count, r.first_dim_count} = d;
      3'h3: r.dst = d;
      3'h4: {r.dbidx, r.sbidx} = d;
      3'h5: {r.brld, r.link} = d;
      3'h6: {r.dcidx, r.scidx} = d;
      default: r.third_dim_count = d[15:0];
    endcase
    put_word = r;
  endfunction

  // ********************************************************
  // State
  // ********************************************************
  dma_chan_pkg::set_a_s sets [dma_chan_pkg::NUM_SETS];
  dma_chan_pkg::set_a_s cur;
  dma_chan_pkg::eng_state_e state;
  logic [63:0] pend;
  logic [63:0] ipend;
  logic [63:0] miss;
  logic [63:0] r0en;
  logic [63:0] r1en;
  logic [63:0] evt_s1;
  logic [63:0] evt_s2;
  logic [63:0] evt_s3;
  logic [63:0] evt_lvl;
  logic [5:0]  ch;
  logic        last;
  logic [6:0]  wmark;
  logic [6:0]  thresh;
  logic [1:0]  err;

  // ********************************************************
  // Register decode
  // ********************************************************
  wire logic        wr_eset_lo  = i_wr && i_addr == dma_chan_pkg::OFF_ESET_LO;
  wire logic        wr_eset_hi  = i_wr && i_addr == dma_chan_pkg::OFF_ESET_HI;
  wire logic        wr_ipend_lo = i_wr && i_addr == dma_chan_pkg::OFF_IPEND_LO;
  wire logic        wr_ipend_hi = i_wr && i_addr == dma_chan_pkg::OFF_IPEND_HI;
  wire logic        wr_miss_lo  = i_wr && i_addr == dma_chan_pkg::OFF_MISS_LO;
  wire logic        wr_miss_hi  = i_wr && i_addr == dma_chan_pkg::OFF_MISS_HI;
  wire logic        wr_err      = i_wr && i_addr == dma_chan_pkg::OFF_ERR;
  wire logic        set_hit     = i_addr >= dma_chan_pkg::OFF_SET_BASE &&
                                  i_addr <= dma_chan_pkg::OFF_SET_END;
  wire logic [11:0] set_off     = i_addr - dma_chan_pkg::OFF_SET_BASE;
  wire logic [5:0]  set_idx     = set_off[10:5];
  wire logic [2:0]  set_word    = set_off[4:2];

  // Manual trigger: only ones matter, zeros leave pending alone
  wire logic [63:0] manual = {wr_eset_hi ? i_wdata : 32'h0,
                              wr_eset_lo ? i_wdata : 32'h0};
  wire logic [63:0] ipend_clr = {wr_ipend_hi ? i_wdata : 32'h0,
                                 wr_ipend_lo ? i_wdata : 32'h0};
  wire logic [63:0] miss_clr = {wr_miss_hi ? i_wdata : 32'h0,
                                wr_miss_lo ? i_wdata : 32'h0};

  // ********************************************************
  // Event capture
  // ********************************************************
  // Second and third stage must agree before a change counts
  wire logic [63:0] evt_agree = ~(evt_s2 ^ evt_s3);
  wire logic [63:0] next_lvl  = (evt_lvl & ~evt_agree) | (evt_s3 & evt_agree);
  wire logic [63:0] evt_rise  = next_lvl & ~evt_lvl;

  // ********************************************************
  // Engine decode
  // ********************************************************
  wire logic [5:0]  pick     = first_one(pend);
  wire logic        take     = state == dma_chan_pkg::ST_IDLE && |pend;
  wire logic        ab       = cur.opt[dma_chan_pkg::OPT_AB_SYNC];
  wire logic        sfifo    = cur.opt[dma_chan_pkg::OPT_SRC_FIFO];
  wire logic        dfifo    = cur.opt[dma_chan_pkg::OPT_DST_FIFO];
  wire logic [5:0]  code     = cur.opt[dma_chan_pkg::OPT_CODE_LSB +: 6];
  wire logic        frame_end = ab || cur.second_dim_count <= 16'h0001;
  wire logic        is_last  = cur.third_dim_count == 16'h0001 && frame_end;
  wire logic        null_set = cur.first_dim_count == 16'h0000 ||
                               cur.second_dim_count == 16'h0000 ||
                               cur.third_dim_count == 16'h0000;
  wire logic        issued   = o_tr.valid && i_tr_ready;
  wire logic        upd      = state == dma_chan_pkg::ST_UPDATE;
  wire logic        fin_en   = cur.opt[dma_chan_pkg::OPT_FIN_IRQ];
  wire logic        int_en   = cur.opt[dma_chan_pkg::OPT_INT_IRQ];
  wire logic        irq_go   = upd && ((last && fin_en) ||
                                       (!last && int_en));
  wire logic        chain_go = upd &&
                    ((last && cur.opt[dma_chan_pkg::OPT_FIN_CHAIN]) ||
                     (!last && cur.opt[dma_chan_pkg::OPT_INT_CHAIN]));
  wire logic [63:0] code_bit = 64'h1 << code;
  wire logic [63:0] chain    = chain_go ? code_bit : 64'h0;
  wire logic [63:0] new_set  = evt_rise | manual | chain;
  wire logic [63:0] take_clr = take ? (64'h1 << pick) : 64'h0;
  wire logic [63:0] next_pend = (pend & ~take_clr) | new_set;
  wire logic [63:0] next_ipend = (ipend & ~ipend_clr) |
                                 (irq_go ? code_bit : 64'h0);
  wire logic [63:0] next_miss = (miss & ~miss_clr) | (new_set & pend);
  wire logic [6:0]  pend_cnt  = count_ones(pend);

  // Address step: fifo sides never move, frame end uses the frame stride
  wire logic [31:0] src_step = frame_end ? sext(cur.scidx) : sext(cur.sbidx);
  wire logic [31:0] dst_step = frame_end ? sext(cur.dcidx) : sext(cur.dbidx);
  dma_chan_pkg::set_a_s adv;
  dma_chan_pkg::set_a_s nullified;
  always_comb begin
    adv = cur;
    nullified = cur;
    nullified.first_dim_count = 16'h0000;
    nullified.second_dim_count = 16'h0000;
    nullified.third_dim_count = 16'h0000;
    adv.src = sfifo ? cur.src : cur.src + src_step;
    adv.dst = dfifo ? cur.dst : cur.dst + dst_step;
    if (frame_end) begin
      adv.third_dim_count = cur.third_dim_count - 16'h0001;
      adv.second_dim_count = cur.brld;
    end else begin
      adv.second_dim_count = cur.second_dim_count - 16'h0001;
    end
  end
  wire logic        has_link = cur.link != dma_chan_pkg::LINK_NULL;
  wire dma_chan_pkg::set_a_s link_set = sets[cur.link[5:0]];
  wire dma_chan_pkg::set_a_s wb_set = !last ? adv :
                                       has_link ? link_set : nullified;

  // ********************************************************
  // Parameter sets
  // ********************************************************
  // Engine write-back wins over a software write in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_wr && set_hit) begin
      sets[set_idx] <= put_word(sets[set_idx], set_word, i_wdata);
    end
    if (upd) begin
      sets[ch] <= wb_set;
    end
  end

  // ********************************************************
  // Event and flag registers
  // ********************************************************
  always_ff @(posedge i_clk) begin
    evt_s1 <= i_dma_evt;
    evt_s2 <= evt_s1;
    evt_s3 <= evt_s2;
    if (i_sys_rst) begin
      evt_lvl <= 64'h0;
      pend    <= 64'h0;
      ipend   <= 64'h0;
      miss    <= 64'h0;
      wmark   <= 7'h00;
    end else begin
      evt_lvl <= next_lvl;
      pend    <= next_pend;
      ipend   <= next_ipend;
      miss    <= next_miss;
      if (pend_cnt > wmark) begin
        wmark <= pend_cnt;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      r0en   <= 64'h0;
      r1en   <= 64'h0;
      thresh <= dma_chan_pkg::THRESH_RST;
      err    <= 2'h0;
    end else begin
      if (i_wr && i_addr == dma_chan_pkg::OFF_R0EN_LO) r0en[31:0]  <= i_wdata;
      if (i_wr && i_addr == dma_chan_pkg::OFF_R0EN_HI) r0en[63:32] <= i_wdata;
      if (i_wr && i_addr == dma_chan_pkg::OFF_R1EN_LO) r1en[31:0]  <= i_wdata;
      if (i_wr && i_addr == dma_chan_pkg::OFF_R1EN_HI) r1en[63:32] <= i_wdata;
      if (i_wr && i_addr == dma_chan_pkg::OFF_THRESH) thresh <= i_wdata[6:0];
      // Null set taken, or threshold crossed; set wins over clear
      err <= (err & ~(wr_err ? i_wdata[1:0] : 2'h0)) |
             {pend_cnt > thresh,
              state == dma_chan_pkg::ST_CHECK && null_set};
    end
  end

  // ********************************************************
  // Transfer engine
  // ********************************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state <= dma_chan_pkg::ST_IDLE;
      ch    <= 6'h00;
      last  <= 1'b0;
      cur   <= '0;
      o_tr  <= '0;
    end else begin
      case (state)
        dma_chan_pkg::ST_IDLE: begin
          if (take) begin
            ch    <= pick;
            cur   <= sets[pick];
            state <= dma_chan_pkg::ST_CHECK;
          end
        end
        dma_chan_pkg::ST_CHECK: begin
          if (null_set) begin
            state <= dma_chan_pkg::ST_IDLE;
          end else begin
            last           <= is_last;
            o_tr.valid     <= 1'b1;
            o_tr.src       <= cur.src;
            o_tr.dst       <= cur.dst;
            o_tr.first_dim_count      <= cur.first_dim_count;
            o_tr.second_dim_count      <= ab ? cur.second_dim_count : 16'h0001;
            o_tr.sbidx     <= cur.sbidx;
            o_tr.dbidx     <= cur.dbidx;
            o_tr.src_fifo  <= sfifo;
            o_tr.dst_fifo  <= dfifo;
            o_tr.code      <= code;
            state          <= dma_chan_pkg::ST_ISSUE;
          end
        end
        dma_chan_pkg::ST_ISSUE: begin
          if (issued) begin
            o_tr.valid <= 1'b0;
            state <= cur.opt[dma_chan_pkg::OPT_EARLY] ?
                     dma_chan_pkg::ST_UPDATE : dma_chan_pkg::ST_WAIT;
          end
        end
        dma_chan_pkg::ST_WAIT: begin
          if (i_tr_done) begin
            state <= dma_chan_pkg::ST_UPDATE;
          end
        end
        dma_chan_pkg::ST_UPDATE: begin
          state <= dma_chan_pkg::ST_IDLE;
        end
        default: begin
          state <= dma_chan_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ********************************************************
  // Read path and outputs
  // ********************************************************
  wire logic [31:0] status = {5'h00, state, 2'h0, ch,
                              1'b0, wmark, 1'b0, pend_cnt};
  wire logic [31:0] rd_val =
    set_hit ? word_of(sets[set_idx], set_word) :
    i_addr == dma_chan_pkg::OFF_PEND_LO  ? pend[31:0] :
    i_addr == dma_chan_pkg::OFF_PEND_HI  ? pend[63:32] :
    i_addr == dma_chan_pkg::OFF_IPEND_LO ? ipend[31:0] :
    i_addr == dma_chan_pkg::OFF_IPEND_HI ? ipend[63:32] :
    i_addr == dma_chan_pkg::OFF_R0EN_LO  ? r0en[31:0] :
    i_addr == dma_chan_pkg::OFF_R0EN_HI  ? r0en[63:32] :
    i_addr == dma_chan_pkg::OFF_R1EN_LO  ? r1en[31:0] :
    i_addr == dma_chan_pkg::OFF_R1EN_HI  ? r1en[63:32] :
    i_addr == dma_chan_pkg::OFF_MISS_LO  ? miss[31:0] :
    i_addr == dma_chan_pkg::OFF_MISS_HI  ? miss[63:32] :
    i_addr == dma_chan_pkg::OFF_STATUS   ? status :
    i_addr == dma_chan_pkg::OFF_THRESH   ? {25'h0, thresh} :
    i_addr == dma_chan_pkg::OFF_ERR      ? {30'h0, err} : 32'h0;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rdata   <= 32'h0;
      o_irq     <= 2'h0;
      o_err_irq <= 1'b0;
    end else begin
      o_rdata   <= i_rd ? rd_val : 32'h0;
      o_irq     <= {|(ipend & r1en), |(ipend & r0en)};
      o_err_irq <= |miss || |err;
    end
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  evt_hold_a: assert property (
    (|evt_rise) |=> ((pend & $past(evt_rise)) == $past(evt_rise)))
    else $error("request event not latched");
  manual_set_a: assert property (
    wr_eset_lo |=> ((pend[31:0] & $past(i_wdata)) == $past(i_wdata)))
    else $error("manual trigger not latched");
  take_clear_a: assert property (
    (take && !new_set[pick]) |=> !pend[$past(pick)])
    else $error("pending bit kept after take");
  ab_frame_a: assert property (
    (state == dma_chan_pkg::ST_CHECK && !null_set && ab)
      |=> o_tr.valid && o_tr.second_dim_count == $past(cur.second_dim_count))
    else $error("frame request has wrong array count");
  a_array_a: assert property (
    (o_tr.valid && !ab) |-> o_tr.second_dim_count == 16'h0001)
    else $error("array request spans more than one array");
  fifo_hold_a: assert property (
    (upd && !last && dfifo) |=> sets[$past(ch)].dst == $past(cur.dst))
    else $error("fifo destination address moved");
  irq_final_a: assert property (
    (upd && last && fin_en) |=> ipend[$past(code)])
    else $error("final completion flag missing");
  irq_mid_a: assert property (
    (upd && !last && !int_en && !ipend[code]
     && !ipend_clr[code]) |=> !ipend[$past(code)])
    else $error("intermediate flag raised while disabled");
  chain_a: assert property (
    chain_go |=> pend[$past(code)])
    else $error("chained channel not triggered");
  irq_out_a: assert property (
    (|(ipend & r0en)) |=> o_irq[0])
    else $error("region zero interrupt not raised");
  tr_hold_a: assert property (
    (o_tr.valid && !i_tr_ready) |=> o_tr.valid && $stable(o_tr.src))
    else $error("request dropped before acceptance");

  ab_seen_c:    cover property (issued && ab);
  link_seen_c:  cover property (upd && last && has_link);
  chain_seen_c: cover property (chain_go);
  early_seen_c: cover property (issued && cur.opt[dma_chan_pkg::OPT_EARLY]);
endmodule

// ### rtl/dma_chan_pkg.sv
// Shared constants and carriers of the DMA channel controller
package dma_chan_pkg;
  // ********************************************************
  // Sizes
  // ********************************************************
  localparam int NUM_CH   = 64;
  localparam int NUM_SETS = 64;
  localparam int AW       = 12;

  // ********************************************************
  // Register byte offsets
  // ********************************************************
  localparam logic [11:0] OFF_PEND_LO  = 12'h000;
  localparam logic [11:0] OFF_PEND_HI  = 12'h004;
  localparam logic [11:0] OFF_ESET_LO  = 12'h008;
  localparam logic [11:0] OFF_ESET_HI  = 12'h00C;
  localparam logic [11:0] OFF_IPEND_LO = 12'h010;
  localparam logic [11:0] OFF_IPEND_HI = 12'h014;
  localparam logic [11:0] OFF_R0EN_LO  = 12'h018;
  localparam logic [11:0] OFF_R0EN_HI  = 12'h01C;
  localparam logic [11:0] OFF_R1EN_LO  = 12'h020;
  localparam logic [11:0] OFF_R1EN_HI  = 12'h024;
  localparam logic [11:0] OFF_MISS_LO  = 12'h028;
  localparam logic [11:0] OFF_MISS_HI  = 12'h02C;
  localparam logic [11:0] OFF_STATUS   = 12'h030;
  localparam logic [11:0] OFF_THRESH   = 12'h034;
  localparam logic [11:0] OFF_ERR      = 12'h038;
  localparam logic [11:0] OFF_SET_BASE = 12'h400;
  localparam logic [11:0] OFF_SET_END  = 12'hBFF;

  // ********************************************************
  // Option word fields
  // ********************************************************
  localparam int OPT_SRC_FIFO   = 0;
  localparam int OPT_DST_FIFO   = 1;
  localparam int OPT_AB_SYNC    = 2;
  localparam int OPT_EARLY      = 11;
  localparam int OPT_CODE_LSB   = 12;
  localparam int OPT_FIN_IRQ    = 20;
  localparam int OPT_INT_IRQ    = 21;
  localparam int OPT_FIN_CHAIN  = 22;
  localparam int OPT_INT_CHAIN  = 23;
  localparam logic [15:0] LINK_NULL = 16'hFFFF;
  localparam logic [6:0]  THRESH_RST = 7'h10;

  // ********************************************************
  // Carriers
  // ********************************************************
  typedef struct packed {
    logic [31:0] opt;
    logic [31:0] src;
    logic [15:0] second_dim_count;
    logic [15:0] first_dim_count;
    logic [31:0] dst;
    logic [15:0] dbidx;
    logic [15:0] sbidx;
    logic [15:0] brld;
    logic [15:0] link;
    logic [15:0] dcidx;
    logic [15:0] scidx;
    logic [15:0] third_dim_count;
  } set_a_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] src;
    logic [31:0] dst;
    logic [15:0] first_dim_count;
    logic [15:0] second_dim_count;
    logic [15:0] sbidx;
    logic [15:0] dbidx;
    logic        src_fifo;
    logic        dst_fifo;
    logic [5:0]  code;
  } tr_s;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_CHECK  = 3'b001,
    ST_ISSUE  = 3'b010,
    ST_WAIT   = 3'b011,
    ST_UPDATE = 3'b100
  } eng_state_e;
endpackage

// ### bench/evt_periph.sv
// Peripheral model that raises request events toward the controller
`timescale 1ns/1ns
module evt_periph (
  input  wire logic        i_clk,
  input  wire logic [63:0] i_data_ready,
  output logic      [63:0] o_dma_evt
);
  logic [2:0] left = 3'h0;
  initial o_dma_evt = '0;
  // Level held 4 cycles so the 3-flop synchroniser cannot miss it
  always @(posedge i_clk) begin
    if (left != 3'h0) begin
      left <= left - 3'h1;
      if (left == 3'h1) begin
        o_dma_evt <= '0;
      end
    end else if (i_data_ready != '0) begin
      o_dma_evt <= i_data_ready;
      left      <= 3'h4;
    end
  end
endmodule

// ### bench/testbench.sv
// Self-checking bench of the DMA channel controller
`timescale 1ns/1ns
module testbench;
  logic              i_clk, i_sys_rst, i_wr, i_rd, i_tr_ready, i_tr_done;
  logic              o_err_irq, got, exp;
  logic [11:0]       i_addr;
  logic [31:0]       i_wdata, o_rdata, rdata, src, dst, sidx, s8, s10, s40;
  logic [63:0]       data_rdy, dma_evt;
  logic [15:0]       first_dim_count, second_dim_count;
  logic [1:0]        o_irq;
  dma_chan_pkg::tr_s o_tr, t;
  int                num_errors = 0;
  int                checks = 0;

  dma_chan_ctrl dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_dma_evt(dma_evt), .o_tr(o_tr),
    .i_tr_ready(i_tr_ready), .i_tr_done(i_tr_done), .o_irq(o_irq),
    .o_err_irq(o_err_irq));
  evt_periph peri_u (.i_clk(i_clk), .i_data_ready(data_rdy),
    .o_dma_evt(dma_evt));

  // ****************************************************
  // Bus and transfer helpers
  // ****************************************************
  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    checks++;
    if (seen !== want) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  // Intermediate enable covers all requests but the last, final the last
  function automatic logic exp_irq(input int m, input int k);
    exp_irq = (k == 0) ? m[1] : m[0];
  endfunction
  task automatic bus(input logic w, r, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= w;
    i_rd    <= r;
    i_addr  <= a;
    i_wdata <= d;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
    bus(1'b0, 1'b0, a, 32'h0);
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a);
    bus(1'b0, 1'b1, a, 32'h0);
    bus(1'b0, 1'b0, a, 32'h0);
    #1 rdata = o_rdata;
  endtask
  task automatic wr_set(input int s, input logic [31:0] opt,
      input logic [15:0] b, c, link);
    logic [31:0] w [8];
    w = '{opt, src, {b, first_dim_count}, dst, sidx, {b, link}, sidx, {16'h0, c}};
    for (int i = 0; i < 8; i++) begin
      wr(12'h400 + 12'(s * 32 + i * 4), w[i]);
    end
  endtask
  task automatic take_tr(output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 40 && !ok; n++) begin
      @(posedge i_clk);
      if (o_tr.valid === 1'b1 && i_tr_ready === 1'b1) begin
        ok = 1'b1;
        t  = o_tr;
      end
    end
  endtask
  task automatic done();
    @(posedge i_clk);
    i_tr_done <= 1'b1;
    @(posedge i_clk);
    i_tr_done <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
  task automatic stop_test();
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************************
  // Clock, watchdog and scenarios
  // ****************************************************
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    num_errors++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h94da));
    {i_sys_rst, i_wr, i_rd, i_tr_ready, i_tr_done} = 5'b10010;
    i_addr   = 12'h000;
    i_wdata  = 32'h0;
    data_rdy = '0;
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    rd(dma_chan_pkg::OFF_THRESH);
    chk(rdata[6:0], dma_chan_pkg::THRESH_RST);
    rd(12'h03C);
    chk(rdata, 32'h0);
    wr(dma_chan_pkg::OFF_R0EN_LO, 32'h0000_000E);
    wr(dma_chan_pkg::OFF_R1EN_HI, 32'h0000_0100);
    // Modes 1..3: final, intermediate, both; two requests each
    // Mode 3 also runs in early completion, so done pulses are ignored
    for (int m = 1; m < 4; m++) begin
      src  = $urandom;
      dst  = $urandom;
      first_dim_count = 16'($urandom_range(255, 1));
      sidx = $urandom & 32'h0FFF_0FFF;
      wr_set(m, 32'(m) << 20 | 32'(m) << 12 | 32'(m / 3) << 11 | 32'h2,
             16'h1, 16'h2, 16'hFFFF);
      for (int k = 0; k < 2; k++) begin
        wr(dma_chan_pkg::OFF_ESET_LO, 32'h1 << m);
        take_tr(got);
        chk(got, 1'b1);
        chk(t.src, src + 32'(k) * {16'h0, sidx[15:0]});
        chk({t.dst, t.dst_fifo}, {dst, 1'b1});
        chk({t.first_dim_count, t.second_dim_count, t.code}, {first_dim_count, 16'h1, 6'(m)});
        chk({t.sbidx, t.dbidx, t.src_fifo},
            {sidx[15:0], sidx[31:16], 1'b0});
        done();
        exp = exp_irq(m, k);
        rd(dma_chan_pkg::OFF_IPEND_LO);
        chk(rdata[m], exp);
        chk(o_irq, {1'b0, exp});
        wr(dma_chan_pkg::OFF_IPEND_LO, 32'h1 << m);
      end
    end
    wr(dma_chan_pkg::OFF_ESET_LO, 32'h0);
    take_tr(got);
    chk(got, 1'b0);
    {src, dst, first_dim_count, sidx} = '0;
    wr_set(35, 32'h0, 16'h0, 16'h0, 16'hFFFF);
    wr(dma_chan_pkg::OFF_ESET_HI, 32'h8);
    take_tr(got);
    chk(got, 1'b0);
    rd(dma_chan_pkg::OFF_ERR);
    chk({rdata[0], o_err_irq}, 2'b11);
    // Blocker on 12, event on 8, chain to 40, link to set 10
    src = $urandom;
    dst = $urandom;
    first_dim_count = 16'($urandom_range(64, 1));
    s40 = src;
    wr_set(40, 32'h0, 16'h1, 16'h1, 16'hFFFF);
    wr_set(12, 32'h0, 16'h1, 16'h1, 16'hFFFF);
    src = $urandom;
    s10 = src;
    wr_set(10, 32'h0, 16'h1, 16'h1, 16'hFFFF);
    src  = $urandom;
    s8   = src;
    second_dim_count = 16'($urandom_range(5, 2));
    wr_set(8, 32'h0052_8004, second_dim_count, 16'h1, 16'h000A);
    i_tr_ready <= 1'b0;
    wr(dma_chan_pkg::OFF_ESET_LO, 32'h1000);
    data_rdy <= 64'h100;
    @(posedge i_clk);
    data_rdy <= '0;
    repeat (8) @(posedge i_clk);
    rd(dma_chan_pkg::OFF_PEND_LO);
    chk(rdata[8], 1'b1);
    i_tr_ready <= 1'b1;
    take_tr(got);
    done();
    take_tr(got);
    chk({got, t.src, t.second_dim_count}, {1'b1, s8, second_dim_count});
    rd(dma_chan_pkg::OFF_PEND_LO);
    chk(rdata[8], 1'b0);
    done();
    take_tr(got);
    chk({got, t.src}, {1'b1, s40});
    chk(o_irq, 2'b10);
    done();
    wr(dma_chan_pkg::OFF_ESET_LO, 32'h100);
    take_tr(got);
    chk({got, t.src}, {1'b1, s10});
    done();
    stop_test();
  end
endmodule
